// ### src/rst_seq_pkg.sv
// Constants for the reset, strap latch and SMBus readiness sequencer
package rst_seq_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    // Times as printed
    localparam int unsigned RST_MIN_NS = 5_000;
    localparam int unsigned STRAP_HOLD_US = 1_000;
    localparam int unsigned SMBUS_RDY_US = 40_000;
    localparam int unsigned ATTACH_RDY_NS = 11_500_000;
    localparam int unsigned POR_US = 1_000;
    // Least times round up to whole cycles
    localparam int unsigned RST_MIN_CYC = (RST_MIN_NS * 100 + 999) / 1000;
    localparam int unsigned STRAP_HOLD_CYC = STRAP_HOLD_US * 100;
    localparam int unsigned SMBUS_RDY_CYC = SMBUS_RDY_US * 100;
    localparam int unsigned ATTACH_RDY_CYC = (ATTACH_RDY_NS + 9) / 10;
    localparam int unsigned POR_CYC = POR_US * 100;
    localparam int unsigned CNT_W = 24;
    localparam logic [15:0] ATTACH_CMD = 16'hAA56;
    localparam int unsigned STRAP_W = 8;
endpackage

// ### src/hold_timer.sv
// Down counter that raises done after a loaded number of cycles
`timescale 1ns/10ps
module hold_timer #(
    parameter int unsigned W = 24
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic load,
    input wire logic [W-1:0] count,
    output logic done
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic done;
    } tmr_s;
    tmr_s tmr_reg;
    tmr_s tmr_next;

    always_comb begin
        tmr_next = tmr_reg;
        if (load) begin
            tmr_next.cnt = count;
            tmr_next.done = 1'b0;
        end else if (tmr_reg.cnt != '0) begin
            tmr_next.cnt = tmr_reg.cnt - 1'b1;
        end else begin
            tmr_next.done = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            tmr_reg <= '0;
        end else begin
            tmr_reg <= tmr_next;
        end
    end

    assign done = tmr_reg.done;
endmodule

// ### src/rst_seq.sv
// Reset filter, strap latch and SMBus slave readiness sequencer
// Function
// - Without reset, straps are sampled at power-up, held 1 ms after supplies.
// - Straps are captured again whenever the reset input is held low for the minimum reset time.
// - Reset strap timing applies only after internal power-on reset completes.
// - Runtime SMBus access forces needed clocks on through suspend.
// - Upstream bus reset is never passed to downstream ports.
`timescale 1ns/10ps
module rst_seq #(
    parameter int unsigned STRAP_W = rst_seq_pkg::STRAP_W,
    parameter int unsigned RST_MIN_CYC = rst_seq_pkg::RST_MIN_CYC,
    parameter int unsigned STRAP_HOLD_CYC = rst_seq_pkg::STRAP_HOLD_CYC,
    parameter int unsigned SMBUS_RDY_CYC = rst_seq_pkg::SMBUS_RDY_CYC,
    parameter int unsigned ATTACH_RDY_CYC = rst_seq_pkg::ATTACH_RDY_CYC,
    parameter int unsigned POR_CYC = rst_seq_pkg::POR_CYC
) (
    input wire logic ref_clk,
    input wire logic srst,
    // Board reset and strap pins
    input wire logic reset_in_n,
    input wire logic [STRAP_W-1:0] strap_pins,
    // SMBus slave and hub core inputs
    input wire logic attach_cmd_ack,
    input wire logic [15:0] attach_cmd_code,
    input wire logic runtime_access_en,
    input wire logic suspend_req,
    input wire logic upstream_bus_reset,
    // Sequenced outputs, each one a register field
    output logic [STRAP_W-1:0] strap_value,
    output logic strap_valid,
    output logic core_reset,
    output logic smbus_ready,
    output logic smbus_addr_ack_en,
    output logic clk_force_on,
    output logic downstream_reset
);
    localparam int unsigned W = rst_seq_pkg::CNT_W;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state
    typedef enum logic [3:0] {
        ST_POR = 4'h1,
        ST_RESET = 4'h2,
        ST_STRAP = 4'h4,
        ST_RUN = 4'h8
    } state_e;

    typedef struct packed {
        state_e st;
        logic por_kick;
        logic por_done;
        logic [W-1:0] low_cnt;
        logic [STRAP_W-1:0] strap;
        logic strap_valid;
        logic core_reset;
        logic smbus_ready;
        logic clk_force;
        logic ds_reset;
    } seq_s;

    seq_s seq_reg;
    seq_s seq_next;
    logic tmr_load;
    logic [W-1:0] tmr_count;
    logic tmr_done;
    logic attach_hit;

    ////////////////////////////////////////////////////////////////////////
    // One timer serves the POR, strap hold and readiness phases; phases never overlap,
    // so one counter sized for the longest phase is enough
    hold_timer #(
        .W(W)
    ) u_timer (
        .ref_clk(ref_clk),
        .srst(srst),
        .load(tmr_load),
        .count(tmr_count),
        .done(tmr_done)
    );

    // Only the attach code restarts readiness; every other command is ignored
    assign attach_hit = attach_cmd_ack &&
        (attach_cmd_code == rst_seq_pkg::ATTACH_CMD);

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        seq_next = seq_reg;
        tmr_load = 1'b0;
        tmr_count = '0;
        seq_next.por_kick = 1'b0;

        // Count consecutive low cycles of the board reset input;
        // saturating at the minimum keeps long holds from wrapping
        if (!reset_in_n) begin
            if (seq_reg.low_cnt != W'(RST_MIN_CYC)) begin
                seq_next.low_cnt = seq_reg.low_cnt + 1'b1;
            end
        end else begin
            seq_next.low_cnt = '0;
        end

        // Latched straps keep following the pins until the hold window closes
        if (!seq_reg.strap_valid && seq_reg.st != ST_RESET) begin
            seq_next.strap = strap_pins;
        end

        case (seq_reg.st)
            // Internal power-on reset; board reset lows are only counted here
            ST_POR: begin
                seq_next.core_reset = 1'b1;
                // The timer is idle out of reset, so the first cycle arms it
                if (seq_reg.por_kick) begin
                    tmr_load = 1'b1;
                    tmr_count = W'(POR_CYC);
                end else if (tmr_done) begin
                    seq_next.por_done = 1'b1;
                    seq_next.strap_valid = 1'b1;
                    seq_next.core_reset = 1'b0;
                    seq_next.st = ST_RUN;
                    tmr_load = 1'b1;
                    tmr_count = W'(SMBUS_RDY_CYC);
                end
            end
            // Board reset held; straps follow the pins, past release until the hold window closes
            ST_RESET: begin
                // Straps are sampled while held low; glitches shorter than the minimum are ignored
                seq_next.strap = strap_pins;
                if (reset_in_n) begin
                    seq_next.core_reset = 1'b0;
                    seq_next.st = ST_STRAP;
                    tmr_load = 1'b1;
                    tmr_count = W'(STRAP_HOLD_CYC);
                end
            end
            // Strap hold window after release
            ST_STRAP: begin
                if (tmr_done) begin
                    seq_next.strap_valid = 1'b1;
                    seq_next.st = ST_RUN;
                    tmr_load = 1'b1;
                    // Strap window is part of the 40 ms readiness delay
                    tmr_count = W'(SMBUS_RDY_CYC - STRAP_HOLD_CYC);
                end
            end
            // Running; attach while not ready is refused, the master is still idle
            ST_RUN: begin
                if (tmr_done && !seq_reg.smbus_ready) begin
                    seq_next.smbus_ready = 1'b1;
                end
                if (attach_hit && seq_reg.smbus_ready) begin
                    seq_next.smbus_ready = 1'b0;
                    tmr_load = 1'b1;
                    tmr_count = W'(ATTACH_RDY_CYC);
                end
            end
            default: begin
                seq_next.st = ST_POR;
            end
        endcase

        // A qualified reset pulse after power-on reset restarts the sequence;
        // a pulse of exactly the minimum length already qualifies
        if (seq_reg.por_done && seq_next.low_cnt == W'(RST_MIN_CYC) && !reset_in_n) begin
            seq_next.st = ST_RESET;
            seq_next.core_reset = 1'b1;
            seq_next.strap_valid = 1'b0;
            seq_next.smbus_ready = 1'b0;
        end
        // Early reset activity before power-on reset finishes is absorbed by the POR path

        // Keep clocks alive in suspend whenever runtime access is requested
        if (runtime_access_en) begin
            seq_next.clk_force = 1'b1;
        end else if (suspend_req && seq_next.smbus_ready) begin
            seq_next.clk_force = 1'b1;
        end else begin
            seq_next.clk_force = 1'b0;
        end

        // Upstream bus reset never reaches downstream ports
        seq_next.ds_reset = seq_next.core_reset;
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            seq_reg <= '{
                st: ST_POR,
                por_kick: 1'b1,
                por_done: 1'b0,
                low_cnt: '0,
                strap: '0,
                strap_valid: 1'b0,
                core_reset: 1'b1,
                smbus_ready: 1'b0,
                clk_force: 1'b0,
                ds_reset: 1'b1
            };
        end else begin
            seq_reg <= seq_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs come straight from the state register, no logic after the flops
    assign strap_value = seq_reg.strap;
    assign strap_valid = seq_reg.strap_valid;
    assign core_reset = seq_reg.core_reset;
    assign smbus_ready = seq_reg.smbus_ready;
    // The slave stays deaf to its address for as long as readiness is low
    assign smbus_addr_ack_en = seq_reg.smbus_ready;
    assign clk_force_on = seq_reg.clk_force;
    assign downstream_reset = seq_reg.ds_reset;
endmodule

// ### verification/rst_seq_monitor.sv
// Checker for the reset, strap latch and SMBus readiness ports
`timescale 1ns/10ps
module rst_seq_monitor #(
    parameter int unsigned STRAP_W = 8
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic attach_cmd_ack,
    input wire logic [15:0] attach_cmd_code,
    input wire logic runtime_access_en,
    input wire logic [STRAP_W-1:0] strap_value,
    input wire logic strap_valid,
    input wire logic core_reset,
    input wire logic smbus_ready,
    input wire logic smbus_addr_ack_en,
    input wire logic clk_force_on,
    input wire logic downstream_reset
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    chk_ack_when_ready: assert property (smbus_addr_ack_en == smbus_ready)
        else $error("address ack enable differs from ready");
    chk_attach_drops_ready: assert property (attach_cmd_ack && smbus_ready &&
        attach_cmd_code == rst_seq_pkg::ATTACH_CMD |=> !smbus_ready)
        else $error("ready kept after attach");
    chk_ack_needs_straps: assert property (smbus_addr_ack_en |-> strap_valid && !core_reset)
        else $error("address ack enabled during reset or before straps");
    chk_ready_needs_straps: assert property (smbus_ready |-> strap_valid)
        else $error("ready before straps latched");
    chk_reset_clears: assert property (core_reset |-> !strap_valid && !smbus_ready)
        else $error("reset left straps or ready set");
    chk_strap_frozen: assert property (strap_valid && $past(strap_valid) |->
        $stable(strap_value)) else $error("latched straps moved");
    chk_clk_forced: assert property (runtime_access_en |=> clk_force_on || core_reset)
        else $error("clocks not forced on");
    chk_no_bus_reset_pass: assert property (downstream_reset == core_reset)
        else $error("downstream reset not from core reset");
    cover property ($rose(smbus_ready));
    cover property ($rose(core_reset));
    cover property ($fell(smbus_ready) && !core_reset);
endmodule
bind rst_seq rst_seq_monitor #(.STRAP_W(STRAP_W)) rst_seq_monitor_i (.ref_clk(ref_clk),
    .srst(srst), .attach_cmd_ack(attach_cmd_ack), .attach_cmd_code(attach_cmd_code),
    .runtime_access_en(runtime_access_en), .strap_value(strap_value),
    .strap_valid(strap_valid), .core_reset(core_reset), .smbus_ready(smbus_ready),
    .smbus_addr_ack_en(smbus_addr_ack_en), .clk_force_on(clk_force_on),
    .downstream_reset(downstream_reset));

// ### verification/board_model.sv
// Board reset, strap pins and SMBus master model
`timescale 1ns/10ps
module board_model (
    input wire logic ref_clk,
    input wire logic smbus_ready,
    output logic reset_in_n,
    output logic [7:0] strap_pins,
    output logic attach_cmd_ack,
    output logic [15:0] attach_cmd_code
);
    // Clock runs from time zero, so it is stable before any release
    initial begin
        reset_in_n = 1'b1;
        strap_pins = 8'hA5;
        attach_cmd_ack = 1'b0;
        attach_cmd_code = 16'h0000;
    end
    // Straps stay put after release until the next pulse
    task automatic pulse(input int n, input logic [7:0] s);
        strap_pins <= s;
        reset_in_n <= 1'b0;
        repeat (n) @(posedge ref_clk);
        reset_in_n <= 1'b1;
    endtask
    task automatic command(input logic [15:0] c);
        if (smbus_ready !== 1'b1) @(posedge smbus_ready);
        attach_cmd_code <= c;
        attach_cmd_ack <= 1'b1;
        @(posedge ref_clk);
        attach_cmd_ack <= 1'b0;
        attach_cmd_code <= ~c;
    endtask
endmodule

// ### verification/rst_seq_bench.sv
// Self-checking bench for the reset and SMBus readiness sequencer
`timescale 1ns/10ps
module rst_seq_bench;
    logic ref_clk;
    logic srst;
    logic runtime_access_en;
    logic suspend_req;
    logic upstream_bus_reset;
    logic reset_in_n, attach_cmd_ack, strap_valid, core_reset, smbus_ready;
    logic smbus_addr_ack_en, clk_force_on, downstream_reset;
    logic [7:0] strap_pins, strap_value;
    logic [15:0] attach_cmd_code;
    int fails = 0;
    int checked = 0;
    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;
    board_model board_model_i (.ref_clk(ref_clk), .smbus_ready(smbus_ready),
        .reset_in_n(reset_in_n), .strap_pins(strap_pins), .attach_cmd_ack(attach_cmd_ack),
        .attach_cmd_code(attach_cmd_code));
    rst_seq #(.RST_MIN_CYC(5), .STRAP_HOLD_CYC(10), .SMBUS_RDY_CYC(40), .ATTACH_RDY_CYC(12),
        .POR_CYC(10)) rst_seq_i (.ref_clk(ref_clk), .srst(srst), .reset_in_n(reset_in_n),
        .strap_pins(strap_pins), .attach_cmd_ack(attach_cmd_ack),
        .attach_cmd_code(attach_cmd_code), .runtime_access_en(runtime_access_en),
        .suspend_req(suspend_req), .upstream_bus_reset(upstream_bus_reset),
        .strap_value(strap_value), .strap_valid(strap_valid), .core_reset(core_reset),
        .smbus_ready(smbus_ready), .smbus_addr_ack_en(smbus_addr_ack_en),
        .clk_force_on(clk_force_on), .downstream_reset(downstream_reset));
    ////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    function automatic logic pick(input int s);
        return s == 0 ? strap_valid : (s == 1 ? smbus_ready : core_reset);
    endfunction
    task automatic wait_for(input int s, input int n);
        for (int i = 0; i < n && pick(s) !== 1'b1; i++) cyc(1);
        cmp(pick(s), 8'h01);
    endtask
    task automatic end_sim;
        if (fails == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // A reset pulse inside the power-on phase must not delay the latch
    task automatic t_power_on;
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        board_model_i.pulse(6, 8'hA5);
        wait_for(0, 9);
        cmp(strap_value, 8'hA5);
        cmp(smbus_ready, 8'h00);
        wait_for(1, 50);
    endtask
    task automatic t_board_reset;
        board_model_i.pulse(4, 8'h3C);
        cyc(2);
        cmp(core_reset, 8'h00);
        cmp(strap_value, 8'hA5);
        board_model_i.pulse(5, 8'h3C);
        #1;
        cmp(core_reset, 8'h01);
        wait_for(0, 20);
        cmp(strap_value, 8'h3C);
        wait_for(1, 50);
    endtask
    task automatic t_attach;
        board_model_i.command(16'h1234);
        cyc(1);
        cmp(smbus_ready, 8'h01);
        board_model_i.command(16'hAA56);
        cyc(1);
        cmp(smbus_ready, 8'h00);
        cmp(smbus_addr_ack_en, 8'h00);
        wait_for(1, 20);
        cmp(smbus_addr_ack_en, 8'h01);
    endtask
    task automatic t_clocks;
        runtime_access_en <= 1'b1;
        upstream_bus_reset <= 1'b1;
        cyc(2);
        cmp(clk_force_on, 8'h01);
        cmp(downstream_reset, 8'h00);
        runtime_access_en <= 1'b0;
        suspend_req <= 1'b1;
        cyc(2);
        cmp(clk_force_on, 8'h01);
        suspend_req <= 1'b0;
        cyc(2);
        cmp(clk_force_on, 8'h00);
    endtask
    initial begin
        srst <= 1'b1;
        runtime_access_en <= 1'b0;
        suspend_req <= 1'b0;
        upstream_bus_reset <= 1'b0;
        t_power_on;
        t_board_reset;
        t_attach;
        t_clocks;
        end_sim;
    end
    initial begin
        #20000;
        fails++;
        end_sim;
    end
endmodule
